// ### core/hvp_params.svh
// Constants for the high-voltage port and segment sharing block
`ifndef HVP_PARAMS_SVH
`define HVP_PARAMS_SVH
`define HVP_IDX_W        16
`define HVP_IDX_P4       16'hFFD4
`define HVP_IDX_P5       16'hFFD5
`define HVP_IDX_P6       16'hFFD6
`define HVP_IDX_SEGCTL   16'hFFE0
`define HVP_IDX_RUNCTL   16'hFFE1
`define HVP_RST_DATA     8'h00
`define HVP_RST_SEL      5'h00
`define HVP_FLAG_BIT     7
`define HVP_SEL_MSB      4
`define HVP_RUN_BIT      0
`define HVP_P4_SEG_BASE  5'h10
`define HVP_P5_SEG_TOP   5'h0F
`define HVP_ALL_SEG      5'h17
`endif

// ### core/hvp_pkg.sv
// Types for the high-voltage port and segment sharing block
package hvp_pkg;
   typedef enum logic [1:0] {HVP_ACTIVE, HVP_SLEEP, HVP_STANDBY, HVP_SUBACTIVE} hvp_mode_e;
   typedef logic [7:0] hvp_byte_t;
endpackage : hvp_pkg

// ### core/hvp_port_segment_share.sv
// Ports 4, 5 and 6 data registers with segment output sharing, behind a Wishbone slave
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "hvp_params.svh"
module hvp_port_segment_share #(
   parameter int ADDR_W = 18
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADDR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire hvp_pkg::hvp_mode_e   power_mode,
   input  wire logic                 key_scan,
   input  wire logic [23:8]          segment_output,
   output logic                      display_run_enable,
   input  wire hvp_pkg::hvp_byte_t   p4_in,
   output hvp_pkg::hvp_byte_t        p4_out,
   output hvp_pkg::hvp_byte_t        p4_oe,
   input  wire hvp_pkg::hvp_byte_t   p5_in,
   output hvp_pkg::hvp_byte_t        p5_out,
   output hvp_pkg::hvp_byte_t        p5_oe,
   input  wire hvp_pkg::hvp_byte_t   p6_in,
   output hvp_pkg::hvp_byte_t        p6_out,
   output hvp_pkg::hvp_byte_t        p6_oe
);
   import hvp_pkg::*;

   function automatic logic seg_on(input logic [4:0] seg, input logic [4:0] sel);
      // Select field gives the highest segment number in use
      return seg <= sel;
   endfunction : seg_on

   hvp_byte_t   p4_q;
   hvp_byte_t   p5_q;
   hvp_byte_t   p6_q;
   logic        flag_q;
   logic [4:0]  sel_q;
   logic        run_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   hvp_byte_t   p4_out_q;
   hvp_byte_t   p4_oe_q;
   hvp_byte_t   p5_out_q;
   hvp_byte_t   p5_oe_q;
   hvp_byte_t   p6_out_q;
   hvp_byte_t   p6_oe_q;

   wire logic [`HVP_IDX_W-1:0] idx = wb_adr_i[`HVP_IDX_W+1:2];
   wire logic req    = wb_cyc_i & wb_stb_i;
   wire logic hit_p4 = (idx == `HVP_IDX_P4);
   wire logic hit_p5 = (idx == `HVP_IDX_P5);
   wire logic hit_p6 = (idx == `HVP_IDX_P6);
   wire logic hit_sc = (idx == `HVP_IDX_SEGCTL);
   wire logic hit_rc = (idx == `HVP_IDX_RUNCTL);
   // Any index outside the five decoded ones answers with zero and ignores writes
   wire logic hit_any = hit_p4 | hit_p5 | hit_p6 | hit_sc | hit_rc;
   // Writes commit on the edge where the master sees ack, never earlier
   wire logic wr_lo  = req & wb_we_i & ack_q & wb_sel_i[0];
   wire logic active = (power_mode == HVP_ACTIVE);
   wire logic hold   = (power_mode == HVP_SLEEP);
   wire logic seg_ok = flag_q & ~key_scan;

   hvp_byte_t seg4;
   hvp_byte_t seg5;
   hvp_byte_t lvl4;
   hvp_byte_t lvl5;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         seg4[i] = seg_ok & seg_on(`HVP_P4_SEG_BASE + 5'(i), sel_q);
         seg5[i] = seg_ok & seg_on(`HVP_P5_SEG_TOP - 5'(i), sel_q);
         lvl4[i] = segment_output[16 + i];
         lvl5[i] = segment_output[15 - i];
      end
   end

   wire hvp_byte_t p4_d = (seg4 & lvl4) | (~seg4 & p4_q);
   wire hvp_byte_t p5_d = (seg5 & lvl5) | (~seg5 & p5_q);
   // Segment pins read the stored bit; port pins read the pad level
   wire hvp_byte_t rd4  = (seg4 & p4_q) | (~seg4 & p4_in);
   wire hvp_byte_t rd5  = (seg5 & p5_q) | (~seg5 & p5_in);
   wire hvp_byte_t rd_sc = {flag_q, 2'b00, sel_q};
   wire hvp_byte_t rd_rc = {7'h00, run_q};
   wire hvp_byte_t rd_byte = hit_p4 ? rd4 :
                             hit_p5 ? rd5 :
                             hit_p6 ? p6_in :
                             hit_sc ? rd_sc :
                             hit_rc ? rd_rc : 8'h00;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q  <= req & ~ack_q;
         rdat_q <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p4_q   <= `HVP_RST_DATA;
         p5_q   <= `HVP_RST_DATA;
         p6_q   <= `HVP_RST_DATA;
         flag_q <= 1'b0;
         sel_q  <= `HVP_RST_SEL;
         run_q  <= 1'b0;
      end
      else if (wr_lo)
      begin
         if (hit_p4) p4_q <= wb_dat_i[7:0];
         if (hit_p5) p5_q <= wb_dat_i[7:0];
         if (hit_p6) p6_q <= wb_dat_i[7:0];
         if (hit_sc) flag_q <= wb_dat_i[`HVP_FLAG_BIT];
         if (hit_sc) sel_q <= wb_dat_i[`HVP_SEL_MSB:0];
         if (hit_rc) run_q <= wb_dat_i[`HVP_RUN_BIT];
      end
   end

   // Pads are registered so sleep can freeze them exactly as they were
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p4_out_q <= 8'h00;
         p4_oe_q  <= 8'h00;
         p5_out_q <= 8'h00;
         p5_oe_q  <= 8'h00;
         p6_out_q <= 8'h00;
         p6_oe_q  <= 8'h00;
      end
      else if (!hold)
      begin
         p4_out_q <= active ? p4_d : 8'h00;
         p4_oe_q  <= {8{active}};
         p5_out_q <= active ? p5_d : 8'h00;
         p5_oe_q  <= {8{active}};
         p6_out_q <= active ? p6_q : 8'h00;
         p6_oe_q  <= {8{active}};
      end
   end

   assign wb_ack_o           = ack_q;
   assign wb_dat_o           = rdat_q;
   // Run enable is only a stored bit; ordering against the select field is software's job
   assign display_run_enable = run_q;
   assign p4_out             = p4_out_q;
   assign p4_oe              = p4_oe_q;
   assign p5_out             = p5_out_q;
   assign p5_oe              = p5_oe_q;
   assign p6_out             = p6_out_q;
   assign p6_oe              = p6_oe_q;

   // Checking helpers
   logic      wrote_q;
   hvp_byte_t rev5;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         rev5[i] = segment_output[15 - i];
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wrote_q <= 1'b0;
      else if (wr_lo)
         wrote_q <= 1'b1;
   end
   wire logic full_seg = flag_q & ~key_scan & (sel_q >= `HVP_ALL_SEG);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wr(logic hit);
      wr_lo && hit;
   endsequence
   sequence s_run2;
      active ##1 active;
   endsequence
   // First cycle of a read request whose index meets the hit condition, under a pin condition
   sequence s_rd(logic hit, logic cond);
      req && !wb_we_i && !ack_q && hit && cond;
   endsequence

   chk_p4_store: assert property (s_wr(hit_p4) |=> p4_q == $past(wb_dat_i[7:0]))
      else $error("port 4 data not stored");
   chk_p5_store: assert property (s_wr(hit_p5) |=> p5_q == $past(wb_dat_i[7:0]))
      else $error("port 5 data not stored");
   chk_p6_store: assert property (s_wr(hit_p6) ##1 active[*2] |-> p6_out == $past(p6_q))
      else $error("port 6 data not driven");
   chk_reset_zero: assert property (!wrote_q |-> (p4_q | p5_q | p6_q) == 8'h00)
      else $error("port data not zero after reset");
   chk_gpio_mode: assert property ((active && !flag_q) ##1 active |-> p4_out == $past(p4_q)
                                   && p5_out == $past(p5_q) && p4_oe == 8'hFF)
      else $error("general port pin not following data");
   chk_seg_map: assert property ((active && full_seg) ##1 active |-> p4_out == $past(segment_output[23:16])
                                 && p5_out == $past(rev5))
      else $error("segment mapping wrong");
   chk_seg_read: assert property ((req && !wb_we_i && !ack_q && hit_p4 && full_seg) |=> wb_ack_o
                                  && wb_dat_o[7:0] == $past(p4_q))
      else $error("segment pin read returned pad level");
   chk_key_scan: assert property ((active && key_scan) ##1 active |-> p5_out == $past(p5_q))
      else $error("key scan did not free segment pins");
   chk_flag_clear: assert property ((wr_lo && hit_sc && !wb_dat_i[`HVP_FLAG_BIT]) ##1 s_run2
                                    |-> !flag_q && p4_out == $past(p4_q))
      else $error("flag clear did not restore port use");
   chk_float: assert property ((power_mode == HVP_STANDBY || power_mode == HVP_SUBACTIVE)
                               |=> p4_oe == 8'h00 && p5_oe == 8'h00 && p6_oe == 8'h00)
      else $error("pins not floating in low power");
   chk_sleep_hold: assert property (hold |=> $stable(p4_out) && $stable(p5_oe) && $stable(p6_out))
      else $error("pins changed during sleep");

   // Bus handshake: one answer per request, one cycle after it is seen
   chk_ack_latency: assert property ((req && !ack_q) |=> wb_ack_o)
      else $error("ack did not follow request");

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_ack_needs_req: assert property (!req |=> !wb_ack_o)
      else $error("ack without request");

   chk_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read lanes not zero");

   chk_unmapped_read: assert property (s_rd(!hit_any, 1'b1) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped index returned data");

   // Register storage: only a committed write moves a data register
   chk_p4_hold_nowr: assert property (!(wr_lo && hit_p4) |=> $stable(p4_q))
      else $error("port 4 data moved without write");

   chk_p5_hold_nowr: assert property (!(wr_lo && hit_p5) |=> $stable(p5_q))
      else $error("port 5 data moved without write");

   chk_p6_hold_nowr: assert property (!(wr_lo && hit_p6) |=> $stable(p6_q))
      else $error("port 6 data moved without write");

   chk_sel_store: assert property (s_wr(hit_sc) |=> sel_q == $past(wb_dat_i[`HVP_SEL_MSB:0]))
      else $error("segment select not stored");

   chk_flag_store: assert property (s_wr(hit_sc) |=> flag_q == $past(wb_dat_i[`HVP_FLAG_BIT]))
      else $error("segment mode flag not stored");

   chk_run_store: assert property (s_wr(hit_rc) |=> run_q == $past(wb_dat_i[`HVP_RUN_BIT]))
      else $error("run enable not stored");

   // Read path: port pins show the pad, segment pins show the stored bit
   chk_p4_gpio_read: assert property (s_rd(hit_p4, !flag_q) |=> wb_dat_o[7:0] == $past(p4_in))
      else $error("port 4 read did not return pad level");

   chk_p5_gpio_read: assert property (s_rd(hit_p5, !flag_q) |=> wb_dat_o[7:0] == $past(p5_in))
      else $error("port 5 read did not return pad level");

   chk_p5_seg_read: assert property (s_rd(hit_p5, full_seg) |=> wb_dat_o[7:0] == $past(p5_q))
      else $error("port 5 segment read returned pad level");

   chk_p6_read: assert property (s_rd(hit_p6, 1'b1) |=> wb_dat_o[7:0] == $past(p6_in))
      else $error("port 6 read did not return pad level");

   // Pad path in the operating modes
   chk_p6_drive: assert property (active |=> p6_out == $past(p6_q))
      else $error("port 6 pads not following data");

   chk_oe_active: assert property (active |=> p4_oe == 8'hFF && p5_oe == 8'hFF && p6_oe == 8'hFF)
      else $error("pins not driven in active mode");

   chk_float_low: assert property ((power_mode == HVP_STANDBY || power_mode == HVP_SUBACTIVE)
                                   |=> p4_out == 8'h00 && p5_out == 8'h00 && p6_out == 8'h00)
      else $error("pin levels not low in low power");

   chk_sleep_rest: assert property (hold |=> $stable(p4_oe) && $stable(p5_out) && $stable(p6_oe))
      else $error("pin enables changed during sleep");

   chk_key_scan_p4: assert property ((active && key_scan) |=> p4_out == $past(p4_q))
      else $error("key scan did not free port 4 pins");

   // Partial selection: only the lowest port 4 pin carries its segment
   chk_seg_partial: assert property ((active && seg_ok && sel_q == `HVP_P4_SEG_BASE)
                                     |=> p4_out[7:1] == $past(p4_q[7:1])
                                     && p4_out[0] == $past(segment_output[16]))
      else $error("partial segment selection wrong");
endmodule : hvp_port_segment_share

// ### verif/hvp_pad_model.sv
// Pad model for one 8-bit high-voltage port as seen from the board
`timescale 1ns/1ps
module hvp_pad_model (
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   output logic      [7:0] pad_level
);
   // Board pull-down takes a released line low, never the last driven value
   assign pad_level = pad_out & pad_oe;
endmodule : hvp_pad_model

// ### verif/hv_port_segment_share_bench.sv
// Self-checking bench for the port and segment sharing block
`timescale 1ns/1ps
`include "hvp_params.svh"
module hv_port_segment_share_bench;
   import hvp_pkg::*;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ks = 0, ack, run;
   logic [17:0] adr = 0;
   logic [3:0]  sel = 4'hF;
   logic [31:0] wdat = 0, rdat;
   logic [23:8] seg = 16'hA5E1;
   hvp_mode_e   mode = HVP_ACTIVE;
   hvp_byte_t   p4o, p4e, p5o, p5e, p6o, p6e, p4i, p5i, p6i, q;
   int          n_fail = 0, checks_done = 0, cyc_cnt = 0;
   // Ordinary cases: index, written byte, byte read back
   logic [15:0] r_idx [4] = '{`HVP_IDX_P4, `HVP_IDX_P5, `HVP_IDX_P6, 16'hFFD7};
   hvp_byte_t   r_dat [4] = '{8'hA5, 8'h3C, 8'h81, 8'h55};
   hvp_byte_t   r_exp [4] = '{8'hA5, 8'h3C, 8'h81, 8'h00};

   always #2 clk = ~clk;

   hvp_port_segment_share i_hvp_port_segment_share (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .power_mode(mode), .key_scan(ks), .segment_output(seg), .display_run_enable(run),
      .p4_in(p4i), .p4_out(p4o), .p4_oe(p4e), .p5_in(p5i), .p5_out(p5o), .p5_oe(p5e),
      .p6_in(p6i), .p6_out(p6o), .p6_oe(p6e)
   );
   hvp_pad_model i_hvp_pad_model_p4 (.pad_out(p4o), .pad_oe(p4e), .pad_level(p4i));
   hvp_pad_model i_hvp_pad_model_p5 (.pad_out(p5o), .pad_oe(p5e), .pad_level(p5i));
   hvp_pad_model i_hvp_pad_model_p6 (.pad_out(p6o), .pad_oe(p6e), .pad_level(p6i));

   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   task automatic chk(input string name, input hvp_byte_t seen, input hvp_byte_t exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Holds the request until ack is sampled, then releases it at that edge
   task automatic wb(input logic w, input logic [15:0] idx, input hvp_byte_t d);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
         n_fail++;
   endtask : wb

   task automatic settle;
      repeat (2) @(posedge clk);
   endtask : settle

   always @(posedge clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 3000)
      begin
         n_fail++;
         summarize();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      chk("oe in reset", p4e, 8'h00);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         wb(1'b0, r_idx[i], 8'h00);
         chk("reset value", q, 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         wb(1'b1, r_idx[i], r_dat[i]);
         wb(1'b0, r_idx[i], 8'h00);
         chk("readback", q, r_exp[i]);
      end
      settle();
      chk("p4 pads", p4o, 8'hA5);
      chk("p5 pads", p5o, 8'h3C);
      chk("p6 pads", p6o, 8'h81);
      // Select field before run enable, as software must
      wb(1'b1, `HVP_IDX_P4, 8'h00);
      wb(1'b1, `HVP_IDX_P5, 8'hFF);
      wb(1'b1, `HVP_IDX_SEGCTL, 8'h90);
      wb(1'b1, `HVP_IDX_RUNCTL, 8'h01);
      settle();
      chk("run enable", {7'h00, run}, 8'h01);
      chk("p5 segments", p5o, 8'h87);
      chk("p4 segments", p4o, 8'h01);
      wb(1'b0, `HVP_IDX_P5, 8'h00);
      chk("p5 segment read", q, 8'hFF);
      wb(1'b0, `HVP_IDX_P4, 8'h00);
      chk("p4 segment read", q, 8'h00);
      ks <= 1'b1;
      settle();
      chk("key scan pads", p5o, 8'hFF);
      ks <= 1'b0;
      wb(1'b1, `HVP_IDX_SEGCTL, 8'h97);
      settle();
      chk("all seg p4", p4o, 8'hA5);
      chk("all seg p5", p5o, 8'h87);
      wb(1'b0, `HVP_IDX_P4, 8'h00);
      chk("p4 all seg read", q, 8'h00);
      wb(1'b0, `HVP_IDX_P5, 8'h00);
      chk("p5 all seg read", q, 8'hFF);
      wb(1'b0, `HVP_IDX_SEGCTL, 8'h00);
      chk("segment control read", q, 8'h97);
      wb(1'b1, `HVP_IDX_SEGCTL, 8'h1F);
      settle();
      chk("flag off p5", p5o, 8'hFF);
      chk("flag off p4", p4o, 8'h00);
      mode <= HVP_SLEEP;
      wb(1'b1, `HVP_IDX_P4, 8'h5A);
      settle();
      chk("sleep hold", p4o, 8'h00);
      chk("sleep oe", p4e, 8'hFF);
      mode <= HVP_STANDBY;
      settle();
      chk("standby oe", p4e, 8'h00);
      mode <= HVP_SUBACTIVE;
      settle();
      chk("subactive oe", p5e, 8'h00);
      mode <= HVP_ACTIVE;
      settle();
      chk("active pads", p4o, 8'h5A);
      rst_n <= 1'b0;
      settle();
      chk("oe mid reset", p5e, 8'h00);
      chk("out mid reset", p4o, 8'h00);
      rst_n <= 1'b1;
      wb(1'b0, `HVP_IDX_P4, 8'h00);
      chk("p4 after reset", q, 8'h00);
      wb(1'b0, `HVP_IDX_P5, 8'h00);
      chk("p5 after reset", q, 8'h00);
      summarize();
   end
endmodule : hv_port_segment_share_bench
